// *** common/cms_pkg.sv ***
// shared constants and carrier types for the cipher mode switch controller
package cms_pkg;

  // ----------------------------------------------------------------
  // message codes (fixed encodings, defined here for request, confirm and grant)
  // ----------------------------------------------------------------
  localparam logic [3:0] MSG_NONE      = 4'h0;
  localparam logic [3:0] MSG_ON_REQ    = 4'h1;
  localparam logic [3:0] MSG_ON_CONF   = 4'h2;
  localparam logic [3:0] MSG_ON_GRANT  = 4'h3;
  localparam logic [3:0] MSG_OFF_REQ   = 4'h4;
  localparam logic [3:0] MSG_OFF_CONF  = 4'h5;
  localparam logic [3:0] MSG_OFF_GRANT = 4'h6;

  // ----------------------------------------------------------------
  // retry windows, counted in own-parity frames
  // ----------------------------------------------------------------
  localparam logic [2:0] PS_REQ_TRIES  = 3'd5; // requests from the portable side
  localparam logic [2:0] FS_CONF_TRIES = 3'd6; // odd frames 2S+1 .. 2S+11

  // ----------------------------------------------------------------
  // init vector layout
  // ----------------------------------------------------------------
  localparam int IV_W       = 35;
  localparam int IV_FN_LSB  = 0;
  localparam int IV_FN_W    = 4;
  localparam int IV_MFN_LSB = 4;
  localparam int IV_MFN_W   = 24;
  localparam int KEY_W      = 64;
  localparam int BEARER_N   = 4;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [IV_MFN_W-1:0] mfn;
    logic [IV_FN_W-1:0]  fn;
  } cms_frame_t;

  typedef struct packed {
    logic       valid;
    logic [3:0] code;
  } cms_msg_t;

  typedef struct packed {
    logic            load;       // keystream generator reload this frame
    logic [IV_W-1:0] iv;
    logic            seg_first;  // first segment used for transmit
  } cms_ksg_t;

endpackage

// *** rtl/cms_iv_gen.sv ***
// init vector builder for the keystream generator
`timescale 1ns/100ps
`default_nettype none
module cms_iv_gen (
  input  wire cms_pkg::cms_frame_t frame_in,
  output logic [cms_pkg::IV_W-1:0] iv_out
);
  // ------------------------------------------------------------
  // frame number low, multiframe number above, top bits zero
  // ------------------------------------------------------------
  assign iv_out = {{(cms_pkg::IV_W - cms_pkg::IV_FN_W - cms_pkg::IV_MFN_W){1'b0}},
                   frame_in.mfn, frame_in.fn};
endmodule
`default_nettype wire

// *** rtl/cms_bearer_mode.sv ***
// per-bearer cipher mode register that follows the connection mode
`timescale 1ns/100ps
`default_nettype none
module cms_bearer_mode (
  input  wire logic                          core_clk_in,
  input  wire logic                          rst_in,
  input  wire logic                          ce_in,
  input  wire logic [cms_pkg::BEARER_N-1:0]  bearer_up_in,
  input  wire logic                          conn_mode_in,
  output logic      [cms_pkg::BEARER_N-1:0]  bearer_enc_out
);
  // ------------------------------------------------------------
  // active bearers track the connection mode; idle bearers clear,
  // so a new bearer takes the current mode when it comes up
  // ------------------------------------------------------------
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      bearer_enc_out <= '0;
    end else if (ce_in) begin
      for (int i = 0; i < cms_pkg::BEARER_N; i++) begin
        bearer_enc_out[i] <= bearer_up_in[i] & conn_mode_in;
      end
    end
  end
endmodule
`default_nettype wire

// *** rtl/cms_ctrl.sv ***
// cipher mode switch controller for both endpoint roles
//
// Summary of operation
// - mode switches only via control messages, duplex bearer
// - portable side sends in even frames, second half
// - fixed side sends in odd frames, first half
// - control messages always sent and taken clear
// - portable side initiates; fixed side only responds
// - mode applies to all bearers, new ones too
// - cipher-on request up to five even frames
// - confirm reported upward, else release with indication
// - portable decrypts from confirm field, discards before
// - grant next even frame, encrypt from it on
// - fixed enters encrypted, confirms odd frames to 2S+11
// - no grant in window: fixed side releases
// - fixed: 2S+1 clear, discard, decrypt from grant
// - cipher-off request likewise, confirm or release
// - portable stops decrypting at off confirm field
// - off grant next even frame, clear onward
// - fixed enters clear, confirms to 2S+11, else releases
// - fixed: 2S+1 encrypted, discard, clear from grant
// - handed-over bearer adopts mode, same key and vector
// - clear mode serves handover; restore is optional
// - init vector: frame, multiframe, zero top bits
// - first segment downlink, second segment uplink
`timescale 1ns/100ps
`default_nettype none
module cms_ctrl (
  input  wire logic                             core_clk_in,
  input  wire logic                             rst_in,
  input  wire logic                             ce_in,
  input  wire logic                             role_fixed_in,
  input  wire logic                             frame_start_in,
  input  wire logic                             half_start_in,
  input  wire cms_pkg::cms_frame_t              frame_in,
  input  wire logic                             duplex_ok_in,
  input  wire logic                             cipher_switch_request_prim_in,
  input  wire logic                             req_encrypt_in,
  input  wire cms_pkg::cms_msg_t                rx_msg_in,
  input  wire logic [cms_pkg::BEARER_N-1:0]     bearer_up_in,
  input  wire logic [cms_pkg::KEY_W-1:0]        cipher_key_in,
  output logic                                  cipher_switch_confirm_prim_out,
  output logic                                  cipher_switch_indication_prim_out,
  output logic                                  link_release_indication_out,
  output cms_pkg::cms_msg_t                     tx_msg_out,
  output logic                                  tx_encrypt_out,
  output logic                                  rx_decrypt_out,
  output logic                                  rx_discard_out,
  output logic                                  conn_encrypted_out,
  output logic                                  busy_out,
  output cms_pkg::cms_ksg_t                     ksg_out,
  output logic [cms_pkg::KEY_W-1:0]             cipher_key_out,
  output logic [cms_pkg::BEARER_N-1:0]          bearer_enc_out
);

  // ------------------------------------------------------------
  // state and helpers
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    CMS_IDLE,
    CMS_PS_REQ,
    CMS_PS_GRANT,
    CMS_FS_CONF,
    CMS_RELEASED
  } cms_state_t;

  cms_state_t                  state;
  logic                        target_on;   // direction of switch in progress
  logic [2:0]                  tries;       // own-parity frames used so far
  logic                        pend_req;    // upper layer request held until even frame
  logic                        tx_mode;
  logic                        rx_mode;
  logic [cms_pkg::IV_W-1:0]    iv_now;

  // even frame test behind even_f, which several places use
  function automatic logic is_even(input cms_pkg::cms_frame_t f);
    return ~f.fn[0];
  endfunction

  // code of the message that matches the switch direction
  function automatic logic [3:0] code_of(input logic on, input logic [1:0] kind);
    unique case (kind)
      2'd0:    return on ? cms_pkg::MSG_ON_REQ   : cms_pkg::MSG_OFF_REQ;
      2'd1:    return on ? cms_pkg::MSG_ON_CONF  : cms_pkg::MSG_OFF_CONF;
      default: return on ? cms_pkg::MSG_ON_GRANT : cms_pkg::MSG_OFF_GRANT;
    endcase
  endfunction

  wire logic even_f  = is_even(frame_in);
  // portable sends in even second half, fixed in odd first half
  wire logic ps_slot = ~role_fixed_in & even_f & half_start_in;
  wire logic fs_slot = role_fixed_in & ~even_f & frame_start_in;
  wire logic rx_v    = rx_msg_in.valid & duplex_ok_in;

  wire logic got_conf  = rx_v & (rx_msg_in.code == code_of(target_on, 2'd1));
  wire logic got_grant = rx_v & (rx_msg_in.code == code_of(target_on, 2'd2));
  wire logic got_on    = rx_v & (rx_msg_in.code == cms_pkg::MSG_ON_REQ);
  wire logic got_off   = rx_v & (rx_msg_in.code == cms_pkg::MSG_OFF_REQ);

  // next modes feed the status flops, so the cipher flags change in the
  // same cycle as the message that switches them, not one cycle later
  wire logic next_rx_mode =
    ((!role_fixed_in && state == CMS_PS_REQ && got_conf)
     || (role_fixed_in && state == CMS_FS_CONF && got_grant)) ? target_on : rx_mode;
  wire logic next_tx_mode =
    (!role_fixed_in && state == CMS_PS_GRANT && ps_slot) ? target_on :
    (role_fixed_in && state == CMS_IDLE && (got_on || got_off)) ? got_on : tx_mode;

  cms_iv_gen u_iv (
    .frame_in (frame_in),
    .iv_out   (iv_now)
  );

  cms_bearer_mode u_bearer (
    .core_clk_in    (core_clk_in),
    .rst_in         (rst_in),
    .ce_in          (ce_in),
    .bearer_up_in   (bearer_up_in),
    .conn_mode_in   (tx_mode),
    .bearer_enc_out (bearer_enc_out)
  );

  // ------------------------------------------------------------
  // upper layer request latch, portable role only
  // ------------------------------------------------------------
  // a request while busy or on the fixed side is dropped: the fixed
  // side never starts a switch of its own
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      pend_req <= 1'b0;
    end else if (ce_in) begin
      if (state == CMS_IDLE && cipher_switch_request_prim_in && !role_fixed_in) begin
        pend_req <= 1'b1;
      end else if (state != CMS_IDLE) begin
        pend_req <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // handshake state machine with retry counter
  // ------------------------------------------------------------
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      state     <= CMS_IDLE;
      target_on <= 1'b0;
      tries     <= 3'd0;
    end else if (ce_in) begin
      unique case (state)
        CMS_IDLE: begin
          tries <= 3'd0;
          if (pend_req && ps_slot) begin
            target_on <= req_encrypt_in;
            state     <= CMS_PS_REQ;
          end else if (role_fixed_in && (got_on || got_off)) begin
            target_on <= got_on;
            state     <= CMS_FS_CONF;
          end
        end
        CMS_PS_REQ: begin
          if (got_conf) begin
            state <= CMS_PS_GRANT;
          end else if (ps_slot) begin
            // counter advances only on own-parity frames
            if (tries == cms_pkg::PS_REQ_TRIES) begin
              state <= CMS_RELEASED;
            end else begin
              tries <= tries + 3'd1;
            end
          end
        end
        CMS_PS_GRANT: begin
          if (ps_slot) begin
            state <= CMS_IDLE;
          end
        end
        CMS_FS_CONF: begin
          if (got_grant) begin
            state <= CMS_IDLE;
          end else if (fs_slot) begin
            if (tries == cms_pkg::FS_CONF_TRIES) begin
              state <= CMS_RELEASED;
            end else begin
              tries <= tries + 3'd1;
            end
          end
        end
        CMS_RELEASED: begin
          state <= CMS_RELEASED; // left only by reset with the connection
        end
        default: begin
          state <= CMS_IDLE;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // transmitted control messages, always clear
  // ------------------------------------------------------------
  // tries counts slots already used, so a slot with tries below the limit
  // carries a message, except the portable slot at tries == PS_REQ_TRIES - 1;
  // the last slot only checks timeout
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      tx_msg_out <= '0;
    end else if (ce_in) begin
      tx_msg_out <= '0;
      if (state == CMS_IDLE && pend_req && ps_slot) begin
        tx_msg_out <= '{valid: 1'b1, code: code_of(req_encrypt_in, 2'd0)};
      end else if (state == CMS_PS_REQ && ps_slot && !got_conf
                   && tries != cms_pkg::PS_REQ_TRIES - 3'd1
                   && tries != cms_pkg::PS_REQ_TRIES) begin
        tx_msg_out <= '{valid: 1'b1, code: code_of(target_on, 2'd0)};
      end else if (state == CMS_PS_GRANT && ps_slot) begin
        tx_msg_out <= '{valid: 1'b1, code: code_of(target_on, 2'd2)};
      end else if (state == CMS_FS_CONF && fs_slot && !got_grant
                   && tries != cms_pkg::FS_CONF_TRIES) begin
        tx_msg_out <= '{valid: 1'b1, code: code_of(target_on, 2'd1)};
      end
    end
  end

  // ------------------------------------------------------------
  // transmit and receive cipher modes
  // ------------------------------------------------------------
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      tx_mode <= 1'b0;
      rx_mode <= 1'b0;
    end else if (ce_in) begin
      if (!role_fixed_in) begin
        // receive switches on the confirm field itself
        if (state == CMS_PS_REQ && got_conf) begin
          rx_mode <= target_on;
        end
        // transmit switches from the grant frame onward
        if (state == CMS_PS_GRANT && ps_slot) begin
          tx_mode <= target_on;
        end
      end else begin
        // fixed side transmit switches at once on the request
        if (state == CMS_IDLE && (got_on || got_off)) begin
          tx_mode <= got_on;
        end
        if (state == CMS_FS_CONF && got_grant) begin
          rx_mode <= target_on;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // receive discard window between first request and answer
  // ------------------------------------------------------------
  // the fixed side still takes frame 2S+1 in the old mode: discard
  // starts only from the next even frame after the request
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      rx_discard_out <= 1'b0;
    end else if (ce_in) begin
      if (state == CMS_PS_REQ) begin
        rx_discard_out <= !got_conf;
      end else if (state == CMS_FS_CONF) begin
        if (got_grant) begin
          rx_discard_out <= 1'b0;
        end else if (frame_start_in && even_f) begin
          rx_discard_out <= 1'b1;
        end
      end else begin
        rx_discard_out <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // primitives to the upper layer, one-cycle pulses
  // ------------------------------------------------------------
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      cipher_switch_confirm_prim_out    <= 1'b0;
      cipher_switch_indication_prim_out <= 1'b0;
      link_release_indication_out       <= 1'b0;
    end else if (ce_in) begin
      cipher_switch_confirm_prim_out    <= state == CMS_PS_REQ && got_conf;
      cipher_switch_indication_prim_out <= state == CMS_FS_CONF && got_grant;
      link_release_indication_out <=
        (state == CMS_PS_REQ && !got_conf && ps_slot && tries == cms_pkg::PS_REQ_TRIES) ||
        (state == CMS_FS_CONF && !got_grant && fs_slot
         && tries == cms_pkg::FS_CONF_TRIES);
    end
  end

  // ------------------------------------------------------------
  // keystream generator control and status outputs
  // ------------------------------------------------------------
  // reload per frame while either direction is ciphered; key and
  // vector are shared by every bearer so a handover reuses them
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      ksg_out            <= '0;
      cipher_key_out     <= '0;
      tx_encrypt_out     <= 1'b0;
      rx_decrypt_out     <= 1'b0;
      conn_encrypted_out <= 1'b0;
      busy_out           <= 1'b0;
    end else if (ce_in) begin
      ksg_out.load       <= frame_start_in & (tx_mode | rx_mode);
      ksg_out.iv         <= iv_now;
      ksg_out.seg_first  <= role_fixed_in;
      cipher_key_out     <= cipher_key_in;
      tx_encrypt_out     <= next_tx_mode;
      rx_decrypt_out     <= next_rx_mode;
      conn_encrypted_out <= tx_mode & rx_mode;
      busy_out           <= state != CMS_IDLE;
    end
  end

endmodule
`default_nettype wire

// *** bench/cms_ctrl_properties.sv ***
// concurrent checks on the ports of the cipher mode switch controller
`timescale 1ns/100ps
`default_nettype none
module cms_ctrl_properties (
  input  wire logic                         core_clk_in,
  input  wire logic                         rst_in,
  input  wire logic                         role_fixed_in,
  input  wire logic                         frame_start_in,
  input  wire logic                         half_start_in,
  input  wire cms_pkg::cms_frame_t          frame_in,
  input  wire logic                         duplex_ok_in,
  input  wire cms_pkg::cms_msg_t            rx_msg_in,
  input  wire logic [cms_pkg::KEY_W-1:0]    cipher_key_in,
  input  wire logic                         cipher_switch_confirm_prim_out,
  input  wire logic                         cipher_switch_indication_prim_out,
  input  wire logic                         link_release_indication_out,
  input  wire cms_pkg::cms_msg_t            tx_msg_out,
  input  wire logic                         tx_encrypt_out,
  input  wire logic                         rx_decrypt_out,
  input  wire logic                         rx_discard_out,
  input  wire logic                         busy_out,
  input  wire cms_pkg::cms_ksg_t            ksg_out,
  input  wire logic [cms_pkg::KEY_W-1:0]    cipher_key_out
);
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (rst_in);

  // a valid control message received on a duplex bearer
  sequence rx_ok(logic [3:0] a, logic [3:0] b);
    rx_msg_in.valid && duplex_ok_in && (rx_msg_in.code == a || rx_msg_in.code == b);
  endsequence

  ps_even_slot_a: assert property (
    !role_fixed_in && tx_msg_out.valid |-> $past(half_start_in) && !$past(frame_in.fn[0]))
    else $error("portable message outside even second half");
  fs_odd_slot_a: assert property (
    role_fixed_in && tx_msg_out.valid |-> $past(frame_start_in) && $past(frame_in.fn[0]))
    else $error("fixed message outside odd first half");
  fs_only_conf_a: assert property (
    role_fixed_in && tx_msg_out.valid |-> tx_msg_out.code == cms_pkg::MSG_ON_CONF
      || tx_msg_out.code == cms_pkg::MSG_OFF_CONF)
    else $error("fixed side sent other than a confirm");
  on_grant_enc_a: assert property (
    tx_msg_out.valid && tx_msg_out.code == cms_pkg::MSG_ON_GRANT |-> tx_encrypt_out)
    else $error("on grant frame not encrypted");
  off_grant_clr_a: assert property (
    tx_msg_out.valid && tx_msg_out.code == cms_pkg::MSG_OFF_GRANT |-> !tx_encrypt_out)
    else $error("off grant frame still encrypted");
  cfm_cause_a: assert property (
    !role_fixed_in ##0 rx_ok(cms_pkg::MSG_ON_CONF, cms_pkg::MSG_OFF_CONF) ##0 busy_out
      |=> cipher_switch_confirm_prim_out && !rx_discard_out
        && rx_decrypt_out == $past(rx_msg_in.code == cms_pkg::MSG_ON_CONF))
    else $error("confirm not reported or decrypt wrong");
  ind_cause_a: assert property (
    cipher_switch_indication_prim_out |-> role_fixed_in && $past(rx_msg_in.valid && duplex_ok_in)
      && ($past(rx_msg_in.code) == cms_pkg::MSG_ON_GRANT
        || $past(rx_msg_in.code) == cms_pkg::MSG_OFF_GRANT))
    else $error("indication without a received grant");
  iv_layout_a: assert property (
    ksg_out.load |-> ksg_out.iv == {7'h00, frame_in} && ksg_out.seg_first == role_fixed_in)
    else $error("init vector or segment order wrong");
  key_reuse_a: assert property (
    !$past(rst_in) |-> cipher_key_out == $past(cipher_key_in))
    else $error("cipher key not carried over");

  // main scenarios reached
  c_confirm: cover property (cipher_switch_confirm_prim_out);
  c_grant: cover property (cipher_switch_indication_prim_out);
  c_release: cover property (link_release_indication_out);
endmodule

bind cms_ctrl cms_ctrl_properties i_cms_ctrl_properties (.core_clk_in, .rst_in,
  .role_fixed_in, .frame_start_in, .half_start_in, .frame_in, .duplex_ok_in, .rx_msg_in,
  .cipher_key_in, .cipher_switch_confirm_prim_out, .cipher_switch_indication_prim_out,
  .link_release_indication_out, .tx_msg_out, .tx_encrypt_out, .rx_decrypt_out,
  .rx_discard_out, .busy_out, .ksg_out, .cipher_key_out);
`default_nettype wire

// *** bench/cms_peer.sv ***
// peer terminal model on the far side of the control message link
`timescale 1ns/100ps
`default_nettype none
module cms_peer (
  input  wire logic               clk_in,
  input  wire logic               rst_in,
  input  wire logic               peer_fixed_in,
  input  wire logic               answer_in,
  input  wire logic               frame_start_in,
  input  wire logic               half_start_in,
  input  wire logic               odd_in,
  input  wire logic               start_in,
  input  wire logic [3:0]         start_code_in,
  input  wire cms_pkg::cms_msg_t  dut_tx_in,
  output cms_pkg::cms_msg_t       rx_msg_out
);
  // ----------------------------------------------------------------
  // answer logic
  // ----------------------------------------------------------------
  logic       pend;
  logic [3:0] code;
  logic [3:0] noise;
  logic       is_req;
  logic       is_conf;

  assign is_req  = dut_tx_in.code == cms_pkg::MSG_ON_REQ || dut_tx_in.code == cms_pkg::MSG_OFF_REQ;
  assign is_conf = dut_tx_in.code == cms_pkg::MSG_ON_CONF || dut_tx_in.code == cms_pkg::MSG_OFF_CONF;

  // idle code bits wander so a stale code is never mistaken for a message
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      pend       <= 1'b0;
      code       <= 4'h0;
      noise      <= 4'h0;
      rx_msg_out <= '0;
    end else begin
      noise      <= noise + 4'h1;
      rx_msg_out <= {1'b0, noise};
      if (pend && (peer_fixed_in ? frame_start_in && odd_in : half_start_in && !odd_in)) begin
        rx_msg_out <= {1'b1, code};
        pend       <= 1'b0;
      end
      if (start_in) begin
        pend <= 1'b1;
        code <= start_code_in;
      end else if (dut_tx_in.valid && answer_in && (peer_fixed_in ? is_req : is_conf)) begin
        pend <= 1'b1;
        code <= dut_tx_in.code + 4'h1; // request to confirm, confirm to grant
      end
    end
  end
endmodule
`default_nettype wire

// *** bench/testbench.sv ***
// self-checking bench for the cipher mode switch controller
`timescale 1ns/100ps
`default_nettype none
module testbench;
  // ----------------------------------------------------------------
  // stimulus, peer and monitors
  // ----------------------------------------------------------------
  logic                core_clk, rst, role, frame_start, half_start, duplex_ok;
  logic                req, req_enc, answer, peer_start, cfm, ind, rel;
  logic                tx_enc, rx_dec, discard, conn_enc;
  logic [3:0]          peer_code, bearer_up, bearer_enc;
  logic [63:0]         key, key_out;
  logic [2:0]          phase;
  cms_pkg::cms_frame_t frame;
  cms_pkg::cms_msg_t   rx_msg, tx_msg;
  int                  n_fail, checked, n_all, n_cfm, n_ind, n_rel;
  int                  n_tx [16];

  cms_ctrl i_cms_ctrl (.core_clk_in(core_clk), .rst_in(rst), .ce_in(1'b1),
    .role_fixed_in(role), .frame_start_in(frame_start), .half_start_in(half_start),
    .frame_in(frame), .duplex_ok_in(duplex_ok), .cipher_switch_request_prim_in(req),
    .req_encrypt_in(req_enc), .rx_msg_in(rx_msg), .bearer_up_in(bearer_up),
    .cipher_key_in(key), .cipher_switch_confirm_prim_out(cfm),
    .cipher_switch_indication_prim_out(ind), .link_release_indication_out(rel),
    .tx_msg_out(tx_msg), .tx_encrypt_out(tx_enc), .rx_decrypt_out(rx_dec),
    .rx_discard_out(discard), .conn_encrypted_out(conn_enc), .busy_out(), .ksg_out(),
    .cipher_key_out(key_out), .bearer_enc_out(bearer_enc));

  cms_peer i_cms_peer (.clk_in(core_clk), .rst_in(rst), .peer_fixed_in(!role),
    .answer_in(answer), .frame_start_in(frame_start), .half_start_in(half_start),
    .odd_in(frame.fn[0]), .start_in(peer_start), .start_code_in(peer_code),
    .dut_tx_in(tx_msg), .rx_msg_out(rx_msg));

  // clock
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // eight cycles a frame, the portable slot halfway through
  always @(negedge core_clk) begin
    phase       <= phase + 3'd1;
    frame_start <= (phase == 3'd7);
    half_start  <= (phase == 3'd3);
    if (phase == 3'd7) frame <= frame + 28'h000_0001;
  end

  // tally what the controller sends and reports
  always @(posedge core_clk) begin
    if (tx_msg.valid === 1'b1) begin
      n_tx[tx_msg.code]++;
      n_all++;
    end
    if (cfm === 1'b1) n_cfm++;
    if (ind === 1'b1) n_ind++;
    if (rel === 1'b1) n_rel++;
  end

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic clear_counts;
    n_all = 0; n_cfm = 0; n_ind = 0; n_rel = 0;
    foreach (n_tx[i]) n_tx[i] = 0;
  endtask

  task automatic do_reset(input logic fixed);
    rst = 1'b1;
    role = fixed;
    repeat (20) @(negedge core_clk);
    rst = 1'b0;
    @(negedge core_clk);
  endtask

  // a request that must draw no message at all
  task automatic probe(input logic via_peer);
    clear_counts();
    peer_code = cms_pkg::MSG_ON_REQ;
    peer_start = via_peer;
    req = !via_peer;
    @(negedge core_clk);
    peer_start = 1'b0;
    req = 1'b0;
    repeat (40) @(negedge core_clk);
    chk(n_all, 0);
  endtask

  // one switch; the peer stays silent for the first quiet messages
  task automatic hs(input logic on, input int quiet);
    logic fixed, seen;
    logic [3:0] out_code, grant;
    int cap, k;
    fixed = role;
    seen = 1'b0;
    out_code = fixed ? (on ? cms_pkg::MSG_ON_CONF : cms_pkg::MSG_OFF_CONF)
                     : (on ? cms_pkg::MSG_ON_REQ : cms_pkg::MSG_OFF_REQ);
    grant = on ? cms_pkg::MSG_ON_GRANT : cms_pkg::MSG_OFF_GRANT;
    cap = fixed ? 6 : 5;
    clear_counts();
    answer = 1'b0;
    peer_code = on ? cms_pkg::MSG_ON_REQ : cms_pkg::MSG_OFF_REQ;
    peer_start = fixed;
    req_enc = on;
    req = !fixed;
    @(negedge core_clk);
    peer_start = 1'b0;
    req = 1'b0;
    for (k = 0; k < 400 && n_cfm + n_ind + n_rel == 0; k++) begin
      if (!seen && n_tx[out_code] > 0) begin
        seen = 1'b1;
        chk(discard, !fixed);
        chk(tx_enc, fixed == on);
      end
      if (n_tx[out_code] >= quiet) answer = 1'b1;
      @(negedge core_clk);
    end
    repeat (24) @(negedge core_clk);
    chk(n_tx[out_code], (quiet < cap) ? quiet + 1 : cap);
    chk(n_rel, quiet >= cap);
    if (quiet < cap) begin
      chk({n_cfm[1:0], n_ind[1:0]}, {1'b0, !fixed, 1'b0, fixed});
      chk(n_tx[grant], !fixed);
      chk({conn_enc, tx_enc, rx_dec, discard}, {on, on, on, 1'b0});
      bearer_up = 4'($urandom);
      repeat (2) @(negedge core_clk);
      chk(bearer_enc, bearer_up & {4{on}});
    end
  endtask

  task automatic test_done;
    $display("checked %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // cut a hang short well past the expected run
  initial begin
    #200_000;
    n_fail++;
    test_done();
  end

  // main sequence: portable role first, then fixed role
  initial begin
    void'($urandom(32'h4162_d8e2));
    rst = 1'b1; role = 1'b0; req = 1'b0; req_enc = 1'b0; answer = 1'b0;
    peer_start = 1'b0; peer_code = 4'h0; duplex_ok = 1'b1; phase = 3'd0;
    frame_start = 1'b0; half_start = 1'b0; frame = 28'($urandom);
    bearer_up = 4'($urandom); key = {$urandom, $urandom};
    n_fail = 0; checked = 0;
    clear_counts();
    do_reset(1'b0);
    chk(key_out, key);
    hs(1'b1, 0);
    hs(1'b0, 2);
    hs(1'b1, 4);
    hs(1'b0, $urandom_range(3, 0));
    hs(1'b1, 5);
    probe(1'b0);
    do_reset(1'b1);
    probe(1'b0);
    duplex_ok = 1'b0;
    probe(1'b1);
    duplex_ok = 1'b1;
    hs(1'b1, 0);
    hs(1'b0, 5);
    hs(1'b1, 9);
    test_done();
  end
endmodule
`default_nettype wire
